// *** rpg_gen.sv ***
// Stream buffer between the symbol generator and the transmit chain
module rpg_fifo #(
  parameter int W = 6,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } rpg_fifo_st_t;
  rpg_fifo_st_t f_q, f_d;
  logic         push, pop;

  // Handshakes from the fill level; depth must be a power of two
  assign in_ready_o  = (f_q.cnt != (AW+1)'(D));
  assign out_valid_o = (f_q.cnt != '0);
  assign out_data_o  = f_q.mem[f_q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and level update
  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.mem[f_q.wp] = in_data_i;
      f_d.wp          = f_q.wp + 1'b1;
    end
    if (pop) begin
      f_d.rp = f_q.rp + 1'b1;
    end
    f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule : rpg_fifo

// Function
// RL1: Short symbol: no prefix, 12 carriers of 16.
// RL2: Short carriers -7..7 follow fixed QPSK table.
// RL3: 64-point: short carriers every fourth bin.
// RL4: 256-point: short carriers every sixteenth bin.
// RL5: Last short repetition is sign inverted.
// RL6: Full preamble: shorts then one long.
// RL7: Long symbol prefix stretched to double length.
// RL8: Long symbol carriers BPSK, fixed pattern.
// RL9: Shortened preamble is long symbol only.
// RL10: Scheduler reserves entry slot; outside party.
// RL11: Entry request waits for slot, long preamble.
// RL12: Entry power from map, peak, sensitivity, margin.
// RL13: Each failed entry raises power one step; the code stops stepping once the retry count reaches RETRY_MAX (15).
// RL14: Codes from 15-stage PRBS, one bit/step.
// RL15: Code length is multiple of 53 bits.
// RL16: Codes 0-47 split in three groups.
// RL17: Code bits sent BPSK on ranging carriers.
// RL18: Code picked at random within purpose group.
// RL19: First-time ranging spans two symbols.
// RL20: Long ranging phase continuous across boundary.
// RL21: Short ranging: one symbol of six.
// RL22: Short ranging only for synced stations.
// RL23: Non-subchannelized ranging uses extended header burst.
// RL24: Generator seed is a configuration input.
module rpg_gen #(
  parameter logic [63:0] LONG_PAT = 64'h5a3c_96e1_0ff0_a55a,
  parameter int          FIFO_D   = 16
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // Preamble control
  input  wire logic              pre_start_i,
  input  wire logic              pre_shortened_i,
  input  wire logic [1:0]        fft_sel_i,
  input  wire logic [4:0]        short_reps_i,
  input  wire logic [9:0]        data_sym_len_i,
  // Ranging control
  input  wire logic              rng_start_i,
  input  wire logic [1:0]        rng_purpose_i,
  input  wire logic              synced_i,
  input  wire logic              ofdma_i,
  input  wire logic [2:0]        rng_mult_i,
  input  wire logic [2:0]        rng_sym_i,
  input  wire logic [14:0]       prbs_seed_i,
  // Network entry
  input  wire logic              entry_req_i,
  input  wire logic              entry_slot_i,
  input  wire logic              entry_fail_i,
  input  wire logic              entry_ok_i,
  input  wire logic signed [7:0] map_burst_tx_power_i,
  input  wire logic signed [7:0] peak_downlink_level_i,
  input  wire logic signed [7:0] rx_sens_i,
  input  wire logic signed [7:0] margin_i,
  input  wire logic signed [7:0] max_tx_power_i,
  // Status
  output logic                   busy_o,
  output logic [5:0]             rng_code_o,
  output logic [2:0]             rng_sym_o,
  output logic                   long_ranging_o,
  output logic                   rng_reject_o,
  output logic                   ext_header_o,
  output logic signed [9:0]      entry_burst_tx_power_o,
  output logic [10:0]            long_cp_len_o,
  // Carrier stream
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic [5:0]             out_data_o
);
  rpg_pkg::rpg_st_t  st_q, st_d;
  logic [3:0]        lg, sh;
  logic [8:0]        nlast, clen;
  logic [9:0]        nfull, mask;
  logic signed [9:0] kk, idx, pwr_c;
  logic [3:0]        t;
  logic              onb, zr, ng, bp, lst, inv, wvalid, fifo_rdy, push;
  logic [4:0]        rlast;
  logic [5:0]        wdata;
  logic [14:0]       prbs_nx;

  // Transform size per selection: 16, 64 or 256 points
  function automatic logic [3:0] rpg_lg(input logic [1:0] s);
    case (s)
      2'h0:    rpg_lg = 4'h4;
      2'h1:    rpg_lg = 4'h6;
      default: rpg_lg = 4'h8;
    endcase
  endfunction : rpg_lg

  // Generator step for 1 + x^4 + x^7 + x^15
  function automatic logic [14:0] rpg_step(input logic [14:0] s);
    rpg_step = {s[13:0], s[14] ^ s[rpg_pkg::TAP_X7] ^ s[rpg_pkg::TAP_X4]}; // [RL14]
  endfunction : rpg_step

  // Bin geometry for the current symbol
  always_comb begin
    lg    = rpg_lg(st_q.fsel);
    sh    = lg - 4'(rpg_pkg::SHORT_FFT_LG);
    nfull = 10'h001 << lg;
    nlast = 9'(nfull - 10'h001);
    kk    = $signed({1'b0, st_q.bin}) - $signed(nfull >> 1);
    mask  = (10'h001 << sh) - 10'h001;
    idx   = kk >>> sh;
    onb   = ((kk & mask) == 10'h000); // [RL3] [RL4]
    t     = 4'(idx + 10'sh007);
    rlast = (st_q.reps == 5'h00) ? 5'h00 : st_q.reps - 5'h01;
    inv   = (st_q.rep == rlast);
    clen  = 9'(rpg_pkg::CODE_UNIT * ((st_q.mult == 3'h0) ? 3'h1 : st_q.mult)); // [RL15]
  end

  // Carrier word for the symbol being emitted
  always_comb begin
    zr     = 1'b0;
    ng     = 1'b0;
    bp     = 1'b1;
    lst    = 1'b0;
    wvalid = 1'b1;
    case (st_q.state)
      rpg_pkg::S_SHORT: begin
        bp = 1'b0;
        zr = ~onb | rpg_pkg::SHORT_ZERO[t]; // [RL1] [RL2]
        ng = rpg_pkg::SHORT_NEG[t] ^ inv;   // [RL5]
      end
      rpg_pkg::S_LONG: begin
        zr  = (kk == 10'sh000);
        ng  = LONG_PAT[st_q.bin[5:0]];    // [RL8]
        lst = (st_q.bin == nlast);
      end
      rpg_pkg::S_CODE: begin
        ng  = st_q.prbs[14];              // [RL17]
        lst = (st_q.bits == clen - 9'h001) & (~st_q.lng | st_q.two);
      end
      default: wvalid = 1'b0;
    endcase
    wdata = {(st_q.state == rpg_pkg::S_CODE) ? rpg_pkg::K_RNG :
             (st_q.state == rpg_pkg::S_LONG) ? rpg_pkg::K_LONG : rpg_pkg::K_SHORT,
             lst, zr, bp, ng};
  end

  assign push    = wvalid & fifo_rdy;
  assign prbs_nx = rpg_step(st_q.prbs);

  // Entry burst power, capped at the available maximum
  always_comb begin
    pwr_c = 10'(map_burst_tx_power_i) - 10'(peak_downlink_level_i) + 10'(rx_sens_i)
          + 10'(margin_i) + $signed(10'(st_q.retries) * rpg_pkg::PWR_STEP); // [RL12] [RL13]
    if (pwr_c > 10'(max_tx_power_i)) begin
      pwr_c = 10'(max_tx_power_i); // [RL12]
    end
  end

  // Sequencer
  always_comb begin
    st_d     = st_q;
    st_d.rej = 1'b0;
    st_d.rnd = {st_q.rnd[6:0], ~(st_q.rnd[7] ^ st_q.rnd[5] ^ st_q.rnd[4] ^ st_q.rnd[3])};
    if (entry_ok_i) begin
      st_d.retries = 4'h0;
    end else if (entry_fail_i && st_q.retries != rpg_pkg::RETRY_MAX) begin
      st_d.retries = st_q.retries + 4'h1; // [RL13]
    end
    case (st_q.state)
      rpg_pkg::S_IDLE: begin
        st_d.fsel  = fft_sel_i;
        st_d.reps  = short_reps_i;
        st_d.bin   = 9'h000;
        st_d.rep   = 5'h00;
        st_d.cplen = 11'({data_sym_len_i, 1'b0}) - 11'(nfull); // [RL7]
        if (entry_req_i) begin
          st_d.fsel  = st_q.fsel;
          st_d.reps  = st_q.reps;
          st_d.cplen = st_q.cplen;
          st_d.pwr   = pwr_c;         // [RL12]
          st_d.state = rpg_pkg::S_WAIT;
        end else if (rng_start_i) begin
          if (rng_purpose_i > rpg_pkg::P_BWREQ ||
              (rng_purpose_i != rpg_pkg::P_INIT &&
               (!synced_i || rng_sym_i >= rpg_pkg::RNG_SYMS))) begin
            st_d.rej   = 1'b1;        // [RL22] [RL21]
            st_d.fsel  = st_q.fsel;
            st_d.reps  = st_q.reps;
            st_d.cplen = st_q.cplen;
          end else if (!ofdma_i) begin
            st_d.ext   = 1'b1;        // [RL23]
            st_d.state = rpg_pkg::S_SHORT;
          end else begin
            st_d.code   = 6'(rng_purpose_i) * rpg_pkg::GRP_SIZE + 6'(st_q.rnd[3:0]); // [RL16] [RL18]
            st_d.prbs   = prbs_seed_i; // [RL24]
            st_d.cstart = prbs_seed_i;
            st_d.lng    = (rng_purpose_i == rpg_pkg::P_INIT); // [RL19]
            st_d.two    = 1'b0;
            st_d.rsym   = (rng_purpose_i == rpg_pkg::P_INIT) ? 3'h0 : rng_sym_i; // [RL21]
            st_d.mult   = rng_mult_i;
            st_d.bits   = 9'h000;
            st_d.cidx   = 6'h00;
            st_d.state  = (st_d.code == 6'h00) ? rpg_pkg::S_CODE : rpg_pkg::S_SKIP;
          end
        end else if (pre_start_i) begin
          st_d.ext   = 1'b0;
          st_d.state = pre_shortened_i ? rpg_pkg::S_LONG : rpg_pkg::S_SHORT; // [RL9]
        end
      end
      rpg_pkg::S_WAIT: begin
        if (entry_slot_i) begin
          st_d.state = rpg_pkg::S_SHORT; // [RL11]
        end
      end
      rpg_pkg::S_SHORT: begin
        if (push) begin
          st_d.bin = st_q.bin + 9'h001;
          if (st_q.bin == nlast) begin
            st_d.bin = 9'h000;
            st_d.rep = st_q.rep + 5'h01;
            if (inv) begin
              st_d.state = rpg_pkg::S_LONG; // [RL6]
            end
          end
        end
      end
      rpg_pkg::S_LONG: begin
        if (push) begin
          st_d.bin = st_q.bin + 9'h001;
          if (st_q.bin == nlast) begin
            st_d.ext   = 1'b0;
            st_d.state = rpg_pkg::S_IDLE; // [RL6]
          end
        end
      end
      rpg_pkg::S_SKIP: begin
        // Run past earlier codes so the chosen number is reached
        st_d.prbs = prbs_nx;
        st_d.bits = st_q.bits + 9'h001;
        if (st_q.bits == clen - 9'h001) begin
          st_d.bits = 9'h000;
          st_d.cidx = st_q.cidx + 6'h01;
          if (st_q.cidx + 6'h01 == st_q.code) begin
            st_d.cstart = prbs_nx;
            st_d.state  = rpg_pkg::S_CODE; // [RL16]
          end
        end
      end
      rpg_pkg::S_CODE: begin
        if (push) begin
          st_d.prbs = prbs_nx; // [RL14]
          st_d.bits = st_q.bits + 9'h001;
          if (st_q.bits == clen - 9'h001) begin
            st_d.bits = 9'h000;
            if (st_q.lng && !st_q.two) begin
              st_d.two  = 1'b1;        // [RL19]
              st_d.prbs = st_q.cstart; // [RL20]
            end else begin
              st_d.state = rpg_pkg::S_IDLE;
            end
          end
        end
      end
      default: st_d.state = rpg_pkg::S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Output buffer; a stalled drain holds the sequencer
  rpg_fifo #(
    .W (rpg_pkg::WORD_W),
    .D (FIFO_D)
  ) u_fifo (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (wvalid),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (wdata),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (out_data_o)
  );

  // Status outputs
  assign busy_o                 = (st_q.state != rpg_pkg::S_IDLE);
  assign rng_code_o             = st_q.code;
  assign rng_sym_o              = st_q.rsym;
  assign long_ranging_o         = st_q.lng;
  assign rng_reject_o           = st_q.rej;
  assign ext_header_o           = st_q.ext;
  assign entry_burst_tx_power_o = st_q.pwr;
  assign long_cp_len_o          = st_q.cplen;

  // Checks
  property p_short16;
    @(posedge clock_i) disable iff (sys_rst_i)
    (push && st_q.state == rpg_pkg::S_SHORT && st_q.fsel == 2'h0 && !inv)
      |-> (wdata[rpg_pkg::F_ZERO] == rpg_pkg::SHORT_ZERO[st_q.bin[3:0] - 4'h1]);
  endproperty
  a_short16: assert property (p_short16) else $error("short carrier zero map wrong"); // [RL2]

  property p_sparse;
    @(posedge clock_i) disable iff (sys_rst_i)
    (push && st_q.state == rpg_pkg::S_SHORT && st_q.fsel != 2'h0 && st_q.bin[1:0] != 2'h0)
      |-> wdata[rpg_pkg::F_ZERO];
  endproperty
  a_sparse: assert property (p_sparse) else $error("short carrier off grid"); // [RL3]

  property p_invert;
    @(posedge clock_i) disable iff (sys_rst_i)
    (push && st_q.state == rpg_pkg::S_SHORT && inv && !wdata[rpg_pkg::F_ZERO])
      |-> (wdata[rpg_pkg::F_NEG] != rpg_pkg::SHORT_NEG[t]);
  endproperty
  a_invert: assert property (p_invert) else $error("last short not inverted"); // [RL5]

  property p_one_long;
    @(posedge clock_i) disable iff (sys_rst_i)
    (push && st_q.state == rpg_pkg::S_SHORT && inv && st_q.bin == nlast)
      |=> (st_q.state == rpg_pkg::S_LONG && st_q.bin == 9'h000);
  endproperty
  a_one_long: assert property (p_one_long) else $error("long symbol not after shorts"); // [RL6]

  property p_shortened;
    @(posedge clock_i) disable iff (sys_rst_i)
    (st_q.state == rpg_pkg::S_IDLE && pre_start_i && pre_shortened_i && !entry_req_i
     && !rng_start_i) |=> (st_q.state == rpg_pkg::S_LONG);
  endproperty
  a_shortened: assert property (p_shortened) else $error("shortened preamble wrong"); // [RL9]

  property p_pwr_cap;
    @(posedge clock_i) disable iff (sys_rst_i)
    (st_q.state == rpg_pkg::S_IDLE && entry_req_i)
      |=> (entry_burst_tx_power_o <= 10'($past(max_tx_power_i)));
  endproperty
  a_pwr_cap: assert property (p_pwr_cap) else $error("entry power above cap"); // [RL12]

  property p_retry;
    @(posedge clock_i) disable iff (sys_rst_i)
    (entry_fail_i && !entry_ok_i && st_q.retries != rpg_pkg::RETRY_MAX)
      |=> (st_q.retries == $past(st_q.retries) + 4'h1);
  endproperty
  a_retry: assert property (p_retry) else $error("retry step missing"); // [RL13]

  property p_prbs;
    @(posedge clock_i) disable iff (sys_rst_i)
    (st_q.state == rpg_pkg::S_SKIP && st_q.bits != clen - 9'h001)
      |=> (st_q.prbs[0] == ($past(st_q.prbs[14]) ^ $past(st_q.prbs[6]) ^ $past(st_q.prbs[3])));
  endproperty
  a_prbs: assert property (p_prbs) else $error("generator step wrong"); // [RL14]

  property p_group;
    @(posedge clock_i) disable iff (sys_rst_i)
    (st_q.state == rpg_pkg::S_IDLE && rng_start_i && ofdma_i && !entry_req_i ##1
     st_q.state != rpg_pkg::S_IDLE) |-> (st_q.code[5:4] == $past(rng_purpose_i));
  endproperty
  a_group: assert property (p_group) else $error("code outside purpose group"); // [RL16]

  property p_unsynced;
    @(posedge clock_i) disable iff (sys_rst_i)
    (st_q.state == rpg_pkg::S_IDLE && rng_start_i && !entry_req_i && !synced_i
     && rng_purpose_i != rpg_pkg::P_INIT) |=> (rng_reject_o && st_q.state == rpg_pkg::S_IDLE);
  endproperty
  a_unsynced: assert property (p_unsynced) else $error("unsynced short ranging taken"); // [RL22]
endmodule : rpg_gen

// *** rpg_mac_model.sv ***
// Far-side model: drains the carrier stream and grants entry intervals
module rpg_mac_model #(
  parameter int SLOT_DLY = 20
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // Drain pacing
  input  wire logic stall_i,
  input  wire logic slow_i,
  output logic      ready_o,
  // Entry interval
  input  wire logic slot_req_i,
  output logic      entry_slot_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DLY = 8'(SLOT_DLY);
  logic       odd_q;
  logic [7:0] wait_q;
  // Ready every cycle, every other cycle, or held off
  assign ready_o = !stall_i && !(slow_i && odd_q);
  // Interval granted as a one-cycle pulse some cycles after the request
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      odd_q        <= 1'b0;
      wait_q       <= 8'h00;
      entry_slot_o <= 1'b0;
    end else begin
      odd_q        <= ~odd_q;
      entry_slot_o <= slot_req_i && (wait_q == DLY);
      if (!slot_req_i) begin
        wait_q <= 8'h00;
      end else if (wait_q <= DLY) begin
        wait_q <= wait_q + 8'h01;
      end
    end
  end
endmodule : rpg_mac_model

// *** rpg_pkg.sv ***
package rpg_pkg;
  // Output word layout
  localparam int unsigned WORD_W = 6;
  localparam int unsigned F_NEG  = 0;
  localparam int unsigned F_BPSK = 1;
  localparam int unsigned F_ZERO = 2;
  localparam int unsigned F_LAST = 3;
  localparam int unsigned F_KIND = 4;
  localparam logic [1:0] K_SHORT = 2'h0;
  localparam logic [1:0] K_LONG  = 2'h1;
  localparam logic [1:0] K_RNG   = 2'h2;
  // Short symbol carriers -7..7, bit 15 covers the unused -8 slot
  localparam logic [15:0] SHORT_ZERO = 16'hc081;
  localparam logic [15:0] SHORT_NEG  = 16'h0334;
  localparam logic [9:0]  SHORT_FFT_LG = 10'h004;
  // Ranging code generator
  localparam int unsigned PRBS_W    = 15;
  localparam int unsigned TAP_X7    = 6;
  localparam int unsigned TAP_X4    = 3;
  localparam logic [8:0]  CODE_UNIT = 9'h035;
  localparam logic [5:0]  GRP_SIZE  = 6'h10;
  localparam logic [1:0]  P_INIT    = 2'h0;
  localparam logic [1:0]  P_BWREQ   = 2'h2;
  localparam logic [2:0]  RNG_SYMS  = 3'h6;
  // Entry power, dB units
  localparam logic [9:0]  PWR_STEP  = 10'h003;
  localparam logic [3:0]  RETRY_MAX = 4'hf;
  localparam int unsigned LONG_MULT = 2;
  // Controller states
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_SHORT, S_LONG, S_SKIP, S_CODE} rpg_state_t;
  // Controller state record
  typedef struct packed {
    rpg_state_t         state;
    logic [1:0]         fsel;
    logic [4:0]         reps;
    logic [4:0]         rep;
    logic [8:0]         bin;
    logic [5:0]         code;
    logic [5:0]         cidx;
    logic [8:0]         bits;
    logic [2:0]         mult;
    logic [PRBS_W-1:0]  prbs;
    logic [PRBS_W-1:0]  cstart;
    logic               lng;
    logic               two;
    logic [2:0]         rsym;
    logic [7:0]         rnd;
    logic [3:0]         retries;
    logic signed [9:0]  pwr;
    logic [10:0]        cplen;
    logic               rej;
    logic               ext;
  } rpg_st_t;
endpackage : rpg_pkg

// *** tb_rpg_gen.sv ***
module tb_rpg_gen;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and far-side controls
  logic              clock_i;
  logic              sys_rst_i = 1'b1;
  logic              stall = 1'b0, slow = 1'b0, slot_req = 1'b0;
  // Preamble and ranging controls
  logic              pre_start_i = 1'b0, pre_shortened_i = 1'b0, rng_start_i = 1'b0;
  logic              synced_i = 1'b0, ofdma_i = 1'b1;
  logic [1:0]        fft_sel_i = 2'h0, rng_purpose_i = 2'h0;
  logic [4:0]        short_reps_i = 5'h02;
  logic [9:0]        data_sym_len_i = 10'h014;
  logic [2:0]        rng_mult_i = 3'h1, rng_sym_i = 3'h0;
  logic [14:0]       prbs_seed_i = 15'h1ace;
  // Network entry
  logic              entry_req_i = 1'b0, entry_fail_i = 1'b0, entry_ok_i = 1'b0;
  logic              entry_slot_i;
  logic signed [7:0] map_burst_tx_power_i = 8'h00, peak_downlink_level_i = 8'h00;
  logic signed [7:0] rx_sens_i = 8'h00, margin_i = 8'h00, max_tx_power_i = 8'h00;
  // Design outputs
  logic              busy_o, long_ranging_o, rng_reject_o, ext_header_o;
  logic              out_valid_o, out_ready_i;
  logic [5:0]        rng_code_o, out_data_o;
  logic [2:0]        rng_sym_o;
  logic signed [9:0] entry_burst_tx_power_o;
  logic [10:0]       long_cp_len_o;
  // Accepted words and counters
  logic [5:0]        q[$];
  int                n_errors = 0;
  int                tests_run = 0;
  // Short carriers -8..7: zero mask and negative mask
  localparam logic [15:0] EXP_Z = 16'h8103;
  localparam logic [15:0] EXP_N = 16'h0668;

  rpg_gen rpg_gen_inst (.*);
  rpg_mac_model rpg_mac_model_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .stall_i(stall), .slow_i(slow),
    .ready_o(out_ready_i), .slot_req_i(slot_req), .entry_slot_o(entry_slot_i)
  );

  // Free-running clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Collect every word the far side takes; sampled mid-cycle, where the handshake is settled
  always @(negedge clock_i) begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) q.push_back(out_data_o);
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Wait, bounded, until the block is idle and the stream is empty
  task automatic drain(input int b);
    repeat (b) begin
      tick(1);
      if (busy_o === 1'b0 && out_valid_o === 1'b0) return;
    end
    chk("timeout", 1, 0);
    report_and_stop();
  endtask : drain

  // One-cycle request pulse: 0 preamble, 1 ranging, 2 entry
  task automatic go(input int which);
    case (which)
      0: pre_start_i = 1'b1;
      1: rng_start_i = 1'b1;
      default: entry_req_i = 1'b1;
    endcase
    tick(1);
    pre_start_i = 1'b0;
    rng_start_i = 1'b0;
    entry_req_i = 1'b0;
  endtask : go

  task automatic chk_pre(input int n, input int reps, input bit shrt);
    int ns;
    int b;
    logic [1:0] c;
    logic [5:0] e;
    logic [5:0] w;
    ns = shrt ? 0 : (reps < 2 ? 1 : reps);
    chk("words", q.size(), (ns + 1) * n);
    if (q.size() != (ns + 1) * n) return;
    for (int k = 0; k < ns * n; k++) begin
      b = k % n - n / 2;
      c = (b % (n / 16) != 0) ? 2'h2 : {EXP_Z[b / (n / 16) + 8], EXP_N[b / (n / 16) + 8]};
      e = {rpg_pkg::K_SHORT, 1'b0, c[1], 1'b0, (c[0] ^ (k >= (ns - 1) * n)) & ~c[1]};
      chk("short", {q[k][5:1], q[k][0] & ~c[1]}, e);
    end
    for (int k = 0; k < n; k++) begin
      w = q[ns * n + k];
      e = {rpg_pkg::K_LONG, k == n - 1, k == n / 2, 1'b1, 1'b0};
      chk("long", w[5:1], e[5:1]);
    end
  endtask : chk_pre

  task automatic chk_rng(input int len, input bit two);
    bit ra;
    bit rb;
    logic [5:0] w;
    ra = 1'b1;
    rb = 1'b1;
    chk("rng_words", q.size(), (two ? 2 : 1) * len);
    if (q.size() != (two ? 2 : 1) * len) return;
    for (int k = 0; k < q.size(); k++) begin
      w = q[k];
      chk("rng_word", w[5:1], {rpg_pkg::K_RNG, k == q.size() - 1, 2'h1});
      if (two && k >= len) chk("rng_rep", w[0], q[k - len][0]);
    end
    // Code bits obey the generator recurrence in either bit order
    for (int k = 0; k + 15 < len; k++) begin
      ra &= ~(q[k][0] ^ q[k + 4][0] ^ q[k + 7][0] ^ q[k + 15][0]);
      rb &= ~(q[k][0] ^ q[k + 8][0] ^ q[k + 11][0] ^ q[k + 15][0]);
    end
    chk("prbs", ra | rb, 1'b1);
  endtask : chk_rng

  task automatic t_pre(input logic [1:0] sel, input int reps, input bit shrt, input int dl,
                       input int hold);
    int n;
    n = sel == 2'h0 ? 16 : (sel == 2'h1 ? 64 : 256);
    q.delete();
    fft_sel_i = sel;
    short_reps_i = 5'(reps);
    pre_shortened_i = shrt;
    data_sym_len_i = 10'(dl);
    stall = hold > 0;
    tick(2);
    chk("cp_len", long_cp_len_o, 2 * dl - n);
    go(0);
    chk("pre_busy", busy_o, 1'b1);
    if (hold > 0) begin
      tick(hold);
      chk("stall", {busy_o, out_valid_o, q.size() != 0}, 3'h6);
      stall = 1'b0;
      slow = 1'b1;
    end
    drain(4000);
    slow = 1'b0;
    chk_pre(n, reps, shrt);
    $display("done preamble size %0d", n);
  endtask : t_pre

  task automatic t_rng(input logic [1:0] p, input logic s, input logic [2:0] sy,
                       input logic [2:0] m, input logic two);
    q.delete();
    rng_purpose_i = p;
    synced_i = s;
    rng_sym_i = sy;
    rng_mult_i = m;
    go(1);
    chk("rng_go", {busy_o, long_ranging_o, rng_sym_o}, {1'b1, two, two ? 3'h0 : sy});
    chk("rng_grp", rng_code_o[5:4], p);
    drain(8000);
    chk_rng(53 * (m == 3'h0 ? 1 : m), two);
    $display("done ranging purpose %0d", p);
  endtask : t_rng

  task automatic t_rej();
    logic [5:0] cs [3] = '{6'h38, 6'h10, 6'h2e};
    for (int i = 0; i < 3; i++) begin
      {rng_purpose_i, synced_i, rng_sym_i} = cs[i];
      go(1);
      chk("rej", {rng_reject_o, busy_o}, 2'h2);
      tick(1);
      chk("rej_end", rng_reject_o, 1'b0);
    end
    $display("done refusals");
  endtask : t_rej

  task automatic t_ofdm();
    q.delete();
    ofdma_i = 1'b0;
    rng_purpose_i = 2'h1;
    synced_i = 1'b1;
    rng_sym_i = 3'h0;
    fft_sel_i = 2'h0;
    short_reps_i = 5'h02;
    pre_shortened_i = 1'b0;
    go(1);
    chk("ext_hdr", ext_header_o, 1'b1);
    drain(1000);
    chk_pre(16, 2, 1'b0);
    chk("ext_end", ext_header_o, 1'b0);
    ofdma_i = 1'b1;
    $display("done regular burst ranging");
  endtask : t_ofdm

  task automatic t_entry(input int mp, input int pk, input int sn, input int mg, input int mx,
                         input int fails, input bit clr, input int e);
    q.delete();
    map_burst_tx_power_i = 8'(mp);
    peak_downlink_level_i = 8'(pk);
    rx_sens_i = 8'(sn);
    margin_i = 8'(mg);
    max_tx_power_i = 8'(mx);
    entry_ok_i = clr;
    entry_fail_i = clr;
    tick(1);
    entry_ok_i = 1'b0;
    entry_fail_i = 1'b0;
    repeat (fails) begin
      tick(1);
      entry_fail_i = 1'b1;
      tick(1);
      entry_fail_i = 1'b0;
    end
    go(2);
    chk("entry_busy", busy_o, 1'b1);
    chk("entry_pwr", {entry_burst_tx_power_o}, {10'(e)});
    tick(5);
    chk("entry_wait", {out_valid_o, q.size() != 0}, 2'h0);
    slot_req = 1'b1;
    drain(1000);
    slot_req = 1'b0;
    chk_pre(16, 2, 1'b0);
    $display("done entry power %0d", e);
  endtask : t_entry

  // Main sequence
  initial begin
    tick(10);
    sys_rst_i = 1'b0;
    tick(1);
    chk("reset", {busy_o, out_valid_o, rng_reject_o, ext_header_o, long_ranging_o}, 0);
    t_pre(2'h0, 2, 1'b0, 20, 0);
    t_pre(2'h1, 3, 1'b0, 80, 40);
    t_pre(2'h2, 0, 1'b0, 300, 0);
    t_pre(2'h3, 4, 1'b1, 300, 0);
    t_rng(2'h0, 1'b0, 3'h0, 3'h1, 1'b1);
    t_rng(2'h1, 1'b1, 3'h3, 3'h2, 1'b0);
    t_rng(2'h2, 1'b1, 3'h5, 3'h0, 1'b0);
    t_rej();
    t_ofdm();
    t_entry(20, -40, -80, 3, 30, 0, 1'b0, -17);
    t_entry(20, -40, -80, 3, 30, 2, 1'b0, -11);
    t_entry(20, -40, -80, 3, 30, 0, 1'b1, -17);
    t_entry(100, -50, -20, 3, 30, 0, 1'b0, 30);
    report_and_stop();
  end
endmodule : tb_rpg_gen
